/* verilog/uvr_pkg.sv */
package uvr_pkg;

    // ------------------------------------------------------------
    // Response byte layout
    // ------------------------------------------------------------
    localparam int       RESP_MSB  = 7;
    localparam int       RESP_LSB  = 6;
    localparam int       RETRY_MSB = 5;
    localparam int       RETRY_LSB = 3;
    localparam int       DLY_MSB   = 2;
    localparam int       DLY_LSB   = 0;
    localparam logic [7:0] RESP_RESET = 8'h00;

    localparam logic [1:0] RESP_IGNORE  = 2'h0;
    localparam logic [1:0] RESP_RIDE    = 2'h1;
    localparam logic [1:0] RESP_SHUT    = 2'h2;
    localparam logic [1:0] RESP_HOLD    = 2'h3;
    localparam logic [2:0] RETRY_NONE   = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int       TIMER_W    = 24;
    localparam int       UNIT_W     = 16;

    typedef enum logic [4:0] {
        UVR_RUN   = 5'h01,
        UVR_RIDE  = 5'h02,
        UVR_WAIT  = 5'h04,
        UVR_HOLD  = 5'h08,
        UVR_LATCH = 5'h10
    } uvr_state_e;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] wr_data;
    } uvr_cfg_s;

    typedef struct packed {
        logic       fault;
        logic       clear_faults;
        logic       status_clear;
        logic       output_cmd_on;
        logic       other_fault;
        logic       bias_ok;
    } uvr_evt_s;

    typedef struct packed {
        uvr_state_e         state;
        logic [7:0]         resp;
        logic [2:0]         attempts;
        logic [TIMER_W-1:0] timer;
        logic               cmd_prev;
        logic               out_en;
        logic               latched;
    } uvr_st_s;

endpackage : uvr_pkg

/* verilog/uvr_fault_response.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Response 00: output keeps running, fault ignored.
// - Response 01: run for programmed delay, then retry behaviour if fault remains.
// - Response 10: disable output at once, then follow retry setting.
// - Response 11: output off while fault present, resumes when fault gone.
// - Retry field bits 5:3 sets restart attempts after fault shutdown.
// - Retry 000: no restart, stay off until fault cleared.
// - Retry 111: retry forever until commanded off, bias lost, other fault.
// - Latched fault cleared by status clear, clear-faults, reset, off/on, bias loss.
// - Delay field n gives 2**n delay units.
// - Retry 1..6: that many restarts spaced by delay, then stay off.
module uvr_fault_response
    import uvr_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic                 clk_en,
    // Response register access
    input  wire uvr_pkg::uvr_cfg_s    cfg,
    input  wire logic [uvr_pkg::UNIT_W-1:0] delay_unit_cycles,
    output logic [7:0]                resp_rd,
    // Fault and clearing events
    input  wire uvr_pkg::uvr_evt_s    evt,
    // Output control and status
    output logic                      out_en,
    output logic                      fault_latched,
    output logic [2:0]                attempts_used
);
    import uvr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Whole block state in one record, registered in one place
    uvr_st_s q;
    uvr_st_s d;

    // ------------------------------------------------------------
    // Delay decode
    // ------------------------------------------------------------
    // Returns the timer load: one less than the delay, as the cycle at zero also counts
    // Zero unit treated as one so a timer never stalls
    // power-of-two delay
    function automatic logic [TIMER_W-1:0] delay_cycles(input logic [2:0] code,
                                                        input logic [UNIT_W-1:0] unit);
        logic [TIMER_W-1:0] base;
        base = {{(TIMER_W-UNIT_W){1'b0}}, unit};
        if (base == '0)
            base = {{(TIMER_W-1){1'b0}}, 1'b1};
        delay_cycles = (base << code) - {{(TIMER_W-1){1'b0}}, 1'b1};
    endfunction : delay_cycles

    // ------------------------------------------------------------
    // Field decode and clear sources
    // ------------------------------------------------------------
    logic [1:0] resp_f;
    logic [2:0] retry_f;
    logic [2:0] dly_f;
    logic       off_edge;
    logic       cleared;
    logic       budget_left;

    always_comb
    begin
        resp_f   = q.resp[RESP_MSB:RESP_LSB];
        retry_f  = q.resp[RETRY_MSB:RETRY_LSB];
        dly_f    = q.resp[DLY_MSB:DLY_LSB];
        off_edge = q.cmd_prev & ~evt.output_cmd_on;
        cleared  = evt.status_clear | evt.clear_faults | off_edge | ~evt.bias_ok;
        budget_left = (retry_f == RETRY_FOREVER) ||
                      (q.attempts < retry_f);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Events act on the state of the last edge only
    always_comb
    begin
        d          = q;
        d.cmd_prev = evt.output_cmd_on;
        if (cfg.wr_en)
            d.resp = cfg.wr_data;
        if (q.timer != '0)
            d.timer = q.timer - {{(TIMER_W-1){1'b0}}, 1'b1};
        unique case (q.state)
            UVR_RUN:
            begin
                d.out_en = evt.output_cmd_on & evt.bias_ok;
                if (evt.fault && q.out_en)
                begin
                    unique case (resp_f)
                        RESP_IGNORE: d.state = UVR_RUN;
                        RESP_RIDE:
                        begin
                            d.state = UVR_RIDE;
                            d.timer = delay_cycles(dly_f, delay_unit_cycles);
                        end
                        RESP_SHUT:
                        begin
                            d.out_en = 1'b0;
                            d.state  = UVR_WAIT;
                            d.timer  = delay_cycles(dly_f, delay_unit_cycles);
                        end
                        RESP_HOLD:
                        begin
                            d.out_en = 1'b0;
                            d.state  = UVR_HOLD;
                        end
                    endcase
                end
            end
            UVR_RIDE:
            begin
                if (!evt.fault)
                    d.state = UVR_RUN;
                else if (q.timer == '0)
                begin
                    d.out_en = 1'b0;
                    d.state  = UVR_WAIT;
                    d.timer  = delay_cycles(dly_f, delay_unit_cycles);
                end
            end
            UVR_WAIT:
            begin
                d.out_en = 1'b0;
                if (!budget_left)
                begin
                    d.state   = UVR_LATCH;
                    d.latched = 1'b1;
                end
                else if (q.timer == '0)
                begin
                    if (retry_f != RETRY_FOREVER)
                        d.attempts = q.attempts + 3'h1;
                    d.out_en = evt.output_cmd_on;
                    d.state  = UVR_RUN;
                end
            end
            UVR_HOLD:
            begin
                d.out_en = 1'b0;
                if (!evt.fault)
                begin
                    d.out_en = evt.output_cmd_on;
                    d.state  = UVR_RUN;
                end
            end
            UVR_LATCH:
            begin
                d.out_en  = 1'b0;
                d.latched = 1'b1;
            end
            default:
            begin
                d.state  = UVR_RUN;
                d.out_en = 1'b0;
            end
        endcase
        // Restart success resets the budget only after a clean run
        if (q.state == UVR_RUN && !evt.fault && q.out_en && q.timer == '0)
            d.attempts = 3'h0;
        // other fault or command off stops retrying
        if ((q.state == UVR_WAIT) && (evt.other_fault || !evt.output_cmd_on))
        begin
            d.state   = UVR_LATCH;
            d.latched = 1'b1;
        end
        // clear latched fault
        // A fresh latch wins over a clear in the same cycle
        if (cleared && q.state != UVR_RUN && !(q.state == UVR_WAIT && d.latched))
        begin
            d.state    = UVR_RUN;
            d.latched  = 1'b0;
            d.attempts = 3'h0;
            d.timer    = '0;
            d.out_en   = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Sync reset; enable low freezes everything
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            q          <= '0;
            q.state    <= UVR_RUN;
            q.resp     <= RESP_RESET;
        end
        else if (clk_en)
            q <= d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Plain taps of the state flops, no logic after them
    assign resp_rd       = q.resp;
    assign out_en        = q.out_en;
    assign fault_latched = q.latched;
    assign attempts_used = q.attempts;

endmodule : uvr_fault_response

/* verification/uvr_fault_response_sva.sv */
`timescale 1ns/1ps
module uvr_fault_response_chk
    import uvr_pkg::*;
(
    // Clock and control
    input wire logic                         clk_sys,
    input wire logic                         srst,
    input wire logic                         clk_en,
    // Register side
    input wire uvr_pkg::uvr_cfg_s            cfg,
    input wire logic [uvr_pkg::UNIT_W-1:0]   delay_unit_cycles,
    input wire logic [7:0]                   resp_rd,
    // Events and output
    input wire uvr_pkg::uvr_evt_s            evt,
    input wire logic                         out_en,
    input wire logic                         fault_latched,
    input wire logic [2:0]                   attempts_used
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic run_ok;
    // No stop request and no config change this cycle
    assign run_ok = clk_en && evt.output_cmd_on && evt.bias_ok && !evt.other_fault && !cfg.wr_en;
    property p_ignore;
        resp_rd[7:6] == RESP_IGNORE && run_ok && out_en |=> out_en;
    endproperty
    a_ignore: assert property (p_ignore) else $error("output dropped while ignoring");
    property p_ride;
        resp_rd[7:6] == RESP_RIDE && $rose(evt.fault) && run_ok && out_en |=> out_en;
    endproperty
    a_ride: assert property (p_ride) else $error("ride-through dropped at once");
    property p_shut;
        resp_rd[7:6] == RESP_SHUT && evt.fault && clk_en && out_en |=> !out_en;
    endproperty
    a_shut: assert property (p_shut) else $error("output kept on after fault");
    property p_hold;
        resp_rd[7:6] == RESP_HOLD && evt.fault && clk_en |=> !out_en;
    endproperty
    a_hold: assert property (p_hold) else $error("output on during fault");
    property p_resume;
        resp_rd[7:6] == RESP_HOLD && !evt.fault && run_ok && !fault_latched |=> ##[0:2] out_en;
    endproperty
    a_resume: assert property (p_resume) else $error("output did not resume");
    property p_budget;
        resp_rd[5:3] != RETRY_FOREVER |-> attempts_used <= resp_rd[5:3];
    endproperty
    a_budget: assert property (p_budget) else $error("attempts beyond budget");
    property p_forever;
        resp_rd[5:3] == RETRY_FOREVER && run_ok && !fault_latched |=> !fault_latched;
    endproperty
    a_forever: assert property (p_forever) else $error("latched in endless retry");
    property p_latch_off;
        fault_latched |-> !out_en;
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("output on while latched");
    property p_clear;
        fault_latched && clk_en && (evt.clear_faults || evt.status_clear) |=> !fault_latched;
    endproperty
    a_clear: assert property (p_clear) else $error("latch not cleared");
    c_latch: cover property (fault_latched);
    c_retry: cover property ($rose(out_en) && evt.fault);
    c_hold: cover property (resp_rd[7:6] == RESP_HOLD && evt.fault);
endmodule : uvr_fault_response_chk

bind uvr_fault_response uvr_fault_response_chk chk (.clk_sys(clk_sys), .srst(srst),
    .clk_en(clk_en), .cfg(cfg), .delay_unit_cycles(delay_unit_cycles), .resp_rd(resp_rd),
    .evt(evt), .out_en(out_en), .fault_latched(fault_latched), .attempts_used(attempts_used));

/* verification/uvr_host_model.sv */
`timescale 1ns/1ps
module uvr_host_model
    import uvr_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Requests to the block
    output uvr_pkg::uvr_cfg_s cfg,
    output uvr_pkg::uvr_evt_s evt
);
    initial cfg = '0;
    initial evt = 6'h05;
    // One-cycle write strobe
    task automatic wr(input logic [7:0] b);
        @(posedge clk_sys) cfg <= {1'b1, b};
        @(posedge clk_sys) cfg <= {1'b0, b};
    endtask : wr
    task automatic drive(input uvr_evt_s e);
        @(posedge clk_sys) evt <= e;
    endtask : drive
endmodule : uvr_host_model

/* verification/tb.sv */
`timescale 1ns/1ps
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin errors++; \
    $display("[FAIL] %s exp %0h got %0h", n, x, g); end end
module tb;
    import uvr_pkg::*;
    logic clk_sys, srst, clk_en, out_en, fault_latched, oe_d;
    logic [UNIT_W-1:0] unit;
    logic [7:0] resp_rd;
    logic [2:0] attempts_used;
    uvr_cfg_s cfg;
    uvr_evt_s evt, e;
    uvr_evt_s idle_e = 6'h05;
    int errors = 0, comparisons = 0, rises = 0;
    uvr_fault_response uut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .cfg(cfg),
        .delay_unit_cycles(unit), .resp_rd(resp_rd), .evt(evt), .out_en(out_en),
        .fault_latched(fault_latched), .attempts_used(attempts_used));
    uvr_host_model host (.clk_sys(clk_sys), .cfg(cfg), .evt(evt));
    initial begin clk_sys = 0; forever #10 clk_sys = ~clk_sys; end
    always @(posedge clk_sys) begin if (out_en === 1'b1 && oe_d === 1'b0) rises++; oe_d <= out_en; end
    task automatic cyc(input int n); repeat (n) @(posedge clk_sys); #1; endtask : cyc
    task automatic flt(input logic v); e.fault = v; host.drive(e); endtask : flt
    task automatic clr();
        e = idle_e; host.drive(e); e.clear_faults = 1; host.drive(e); e = idle_e; host.drive(e);
        cyc(4);
    endtask : clr
    task automatic gap(input int x);
        int g = 0;
        while (out_en !== 1'b1) begin @(posedge clk_sys); #1; end
        while (out_en !== 1'b0) begin @(posedge clk_sys); #1; end
        while (out_en === 1'b0 && g < 400) begin @(posedge clk_sys); #1; g++; end
        `CHK("retry gap", x, g)
    endtask : gap
    task automatic stop_test();
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin #400us; errors++; stop_test(); end
    initial begin
        srst = 1; clk_en = 1; unit = 16'h0002; e = idle_e;
        cyc(8); srst <= 0; cyc(3);
        `CHK("reset resp", RESP_RESET, resp_rd)
        `CHK("run out_en", 1'b1, out_en)
        host.wr(8'hA5); #1 `CHK("readback", 8'hA5, resp_rd)
        host.wr(8'h00); flt(1); cyc(20); `CHK("ignore", 1'b1, out_en)
        flt(0); host.wr({RESP_RIDE, RETRY_NONE, 3'h2}); flt(1);
        cyc(6); `CHK("ride on", 1'b1, out_en)
        cyc(12); `CHK("ride off", 1'b0, out_en)
        `CHK("ride latch", 1'b1, fault_latched)
        clr(); host.wr({RESP_HOLD, RETRY_NONE, 3'h0}); flt(1);
        cyc(3); `CHK("hold off", 1'b0, out_en)
        flt(0); cyc(4); `CHK("hold resume", 1'b1, out_en)
        for (int n = 0; n < 7; n += (n < 1) ? 1 : (n < 3 ? 2 : 3)) begin
            host.wr({RESP_SHUT, 3'(n), 3'h1}); rises = 0; flt(1); cyc(80);
            `CHK("restarts", n, rises)
            `CHK("attempts", 3'(n), attempts_used)
            `CHK("latched", 1'b1, fault_latched)
            clr(); `CHK("cleared", 1'b0, fault_latched)
        end
        host.wr({RESP_SHUT, RETRY_FOREVER, 3'h2}); flt(1); gap(8); gap(8);
        host.wr({RESP_SHUT, RETRY_FOREVER, 3'h3}); gap(16); cyc(60);
        `CHK("no latch", 1'b0, fault_latched)
        e.other_fault = 1; host.drive(e); cyc(40); `CHK("other stop", 1'b0, out_en)
        clr();
        for (int m = 0; m < 4; m++) begin
            host.wr({RESP_SHUT, RETRY_NONE, 3'h0}); flt(1); cyc(8); flt(0);
            e.clear_faults = (m == 0); e.status_clear = (m == 1);
            e.output_cmd_on = (m != 2); e.bias_ok = (m != 3); host.drive(e);
            e = idle_e; host.drive(e); cyc(4);
            `CHK("clear way", 1'b0, fault_latched)
            `CHK("back on", 1'b1, out_en)
        end
        host.wr(8'h91); srst <= 1; cyc(2); srst <= 0; cyc(3);
        `CHK("reset clears", RESP_RESET, resp_rd)
        stop_test();
    end
endmodule : tb
